// [hw/apdp_regs.vh]
/*
 * Constants of the asynchronous parallel display port: field widths,
 * encodings, timing limits and reset levels.
 * Assumes it is included by bare name from the design files.
 */
`ifndef APDP_REGS_VH
`define APDP_REGS_VH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define APDP_TW          8
`define APDP_DW          16
`define APDP_BLW         8
`define APDP_NDISP       3
`define APDP_DSW         2

// ----------------------------------------------------------------
// Bus family, sampling type and transfer mode encodings
// ----------------------------------------------------------------
`define APDP_FAM_80      1'h0
`define APDP_FAM_68K     1'h1
`define APDP_TYPE1       1'h0
`define APDP_TYPE2       1'h1
`define APDP_MODE_BURST  2'h0
`define APDP_MODE_BCLK   2'h1
`define APDP_MODE_SINGLE 2'h2

// ----------------------------------------------------------------
// Timing limits: pause in fast interface clock cycles, read wait states in interface periods
// ----------------------------------------------------------------
`define APDP_GAP_BASE    5'h04
`define APDP_GAP_MAX     5'h13
`define APDP_WAIT_MAX    3'h4
`define APDP_WAIT_W      3

// ----------------------------------------------------------------
// Reset levels of the phase counters and outputs
// ----------------------------------------------------------------
`define APDP_ZERO_T      8'h00
`define APDP_ONE_T       8'h01
`define APDP_ONE_BL      8'h01
`define APDP_ZERO_BL     8'h00
`define APDP_ZERO_D      16'h0000

`endif

// [hw/apdp_sync2.v]
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the level is stable for longer than two clock periods.
 */
`timescale 1ns/10ps
module apdp_sync2 (
    // Clock and reset
    input  wire clk,
    input  wire reset_n,
    // Level in and out
    input  wire din,
    output wire dout
);
    reg meta_q;
    reg sync_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// [hw/apdp_timing.v]
/*
 * Converts programmed times into counts of half fast-clock cycles.
 * Assumes the fast clock period setting is nonzero and stable per access.
 */
`timescale 1ns/10ps
`include "apdp_regs.vh"
module apdp_timing (
    // Programmed times
    input  wire [`APDP_TW-1:0]   fast_clock_period_setting,
    input  wire [`APDP_TW-1:0]   cycle_length,
    input  wire [`APDP_TW-1:0]   strobe_fall_point,
    input  wire [`APDP_TW-1:0]   strobe_rise_point,
    input  wire [`APDP_TW-1:0]   read_sample_point,
    // Counts in half cycles
    output wire [`APDP_TW+1:0]   period_half,
    output wire [`APDP_TW+1:0]   fall_half,
    output wire [`APDP_TW+1:0]   rise_half,
    output wire [`APDP_TW+1:0]   sample_half
);
    // Ceiling division; numerator has one extra bit for the doubled value
    function [`APDP_TW:0] ceil_div;
        input [`APDP_TW:0]   num;
        input [`APDP_TW-1:0] den;
        reg   [`APDP_TW:0]   dd;
        begin
            dd = {1'b0, den};
            if (dd == {(`APDP_TW+1){1'b0}})
                ceil_div = num;
            else
                ceil_div = (num + dd - 1'b1) / dd;
        end
    endfunction

    // Whole-cycle values are doubled so one half-cycle counter serves all
    assign period_half = {ceil_div({1'b0, cycle_length}, fast_clock_period_setting), 1'b0};
    assign fall_half   = {1'b0, ceil_div({strobe_fall_point, 1'b0},
                                         fast_clock_period_setting)};
    assign rise_half   = {1'b0, ceil_div({strobe_rise_point, 1'b0},
                                         fast_clock_period_setting)};
    assign sample_half = {ceil_div({1'b0, read_sample_point},
                                   fast_clock_period_setting), 1'b0};
endmodule

// [hw/apdp_port.v]
/*
 * Asynchronous parallel display port engine: 80-style and 68k-style
 * buses, type 1 and type 2 sampling, three transfer modes, pauses,
 * read wait states and per-signal polarity.
 * Assumes clk is the fast interface clock; configuration is held stable
 * while busy; the source offers words with valid/ready.
 */
`timescale 1ns/10ps
`include "apdp_regs.vh"

// What this block does
// - Offers 80-style read/write strobe bus and 68k-style enable strobe bus.
// - Type 1 latches on chip select, type 2 on strobes; byte enables optional.
// - Three modes for every variant: strobe burst, burst clock, single access.
// - Burst length comes from DMA parameters or the slave bus burst code.
// - Type 1 bursts: select pulses per word; address and byte enable lines drop with it between words.
// - Type 2 bursts: strobes latch words; select held over whole burst.
// - Burst clock mode: burst clock latches data, select held for burst.
// - Burst clock mode: controls switch with data when bus state changes.
// - Burst clock mode: all controls go inactive after the burst.
// - Single mode splits every burst into separate accesses.
// - Single mode: all controls inactive one interface period after each access.
// - Pause of 4 to 19 fast cycles between bursts and display changes.
// - Read wait states stretch each read to at most 4 interface periods.
// - Each control output has programmable polarity; reference is active low.
// - Access period is fast period times ceil(cycle length over clock setting).
// - Strobe edges at half-cycle steps: ceil(2 times value over setting).
// - Read capture at ceil(sample value over setting) fast cycles.
module apdp_port (
    // Clock and reset
    input  wire                    clk,
    input  wire                    reset_n,
    // Interface configuration
    input  wire                    bus_family,
    input  wire                    sample_type,
    input  wire                    byte_enable_on,
    input  wire [1:0]              transfer_mode,
    input  wire [3:0]              pause_setting,
    input  wire [`APDP_WAIT_W-1:0] read_wait_states,
    input  wire [5:0]              signal_polarity_select,
    // Timing configuration
    input  wire [`APDP_TW-1:0]     fast_clock_period_setting,
    input  wire [`APDP_TW-1:0]     write_cycle_length,
    input  wire [`APDP_TW-1:0]     read_cycle_length,
    input  wire [`APDP_TW-1:0]     write_strobe_fall_point,
    input  wire [`APDP_TW-1:0]     write_strobe_rise_point,
    input  wire [`APDP_TW-1:0]     read_strobe_fall_point,
    input  wire [`APDP_TW-1:0]     read_strobe_rise_point,
    input  wire [`APDP_TW-1:0]     read_sample_point,
    // Burst source
    input  wire                    src_from_dma,
    input  wire [`APDP_BLW-1:0]    dma_burst_length,
    input  wire [2:0]              hburst,
    // Access stream
    input  wire                    acc_valid,
    output wire                    acc_ready,
    input  wire                    acc_read,
    input  wire [`APDP_DSW-1:0]    acc_display,
    input  wire                    acc_addr,
    input  wire [1:0]              acc_byte_en,
    input  wire [`APDP_DW-1:0]     acc_wdata,
    output reg  [`APDP_DW-1:0]     rd_data_q,
    output reg                     rd_valid_q,
    output wire                    busy,
    // Display pins
    output reg  [`APDP_NDISP-1:0]  display_select,
    output reg                     write_strobe,
    output reg                     read_strobe,
    output reg                     burst_strobe_clock,
    output reg                     addr_sel,
    output reg  [1:0]              byte_enable,
    output reg  [`APDP_DW-1:0]     data_out_q,
    output reg                     data_oe_n_q,
    input  wire [`APDP_DW-1:0]     data_in
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_XFER = 5'h02;
    localparam [4:0] S_NEXT = 5'h04;
    localparam [4:0] S_OFF  = 5'h08;
    localparam [4:0] S_GAP  = 5'h10;

    reg  [4:0]             state_q;
    reg  [`APDP_TW+1:0]    half_q;
    reg  [`APDP_WAIT_W-1:0] wait_q;
    reg  [`APDP_BLW-1:0]   left_q;
    reg  [4:0]             gap_q;
    reg  [`APDP_DSW-1:0]   disp_q;
    reg                    rd_q;
    reg                    addr_q;
    reg  [1:0]             be_q;
    reg                    sel_act_q;
    reg                    str_act_q;
    reg                    sampled_q;
    wire [`APDP_DW-1:0]    din_sync;

    // Read data comes from the display pins, so it is synchronised first
    genvar gi;
    generate
        for (gi = 0; gi < `APDP_DW; gi = gi + 1) begin : g_sync
            apdp_sync2 u_sync (
                .clk     (clk),
                .reset_n (reset_n),
                .din     (data_in[gi]),
                .dout    (din_sync[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Timing conversion
    // ----------------------------------------------------------------
    wire [`APDP_TW+1:0] per_h;
    wire [`APDP_TW+1:0] fall_h;
    wire [`APDP_TW+1:0] rise_h;
    wire [`APDP_TW+1:0] samp_h;

    apdp_timing u_timing (
        .fast_clock_period_setting (fast_clock_period_setting),
        .cycle_length              (rd_q ? read_cycle_length : write_cycle_length),
        .strobe_fall_point         (rd_q ? read_strobe_fall_point : write_strobe_fall_point),
        .strobe_rise_point         (rd_q ? read_strobe_rise_point : write_strobe_rise_point),
        .read_sample_point         (read_sample_point),
        .period_half               (per_h),
        .fall_half                 (fall_h),
        .rise_half                 (rise_h),
        .sample_half               (samp_h)
    );

    // ----------------------------------------------------------------
    // Burst length decode
    // ----------------------------------------------------------------
    function [`APDP_BLW-1:0] hburst_len;
        input [2:0] hb;
        begin
            case (hb)
                3'h2, 3'h3: hburst_len = 8'h04;
                3'h4, 3'h5: hburst_len = 8'h08;
                3'h6, 3'h7: hburst_len = 8'h10;
                default:    hburst_len = 8'h01;
            endcase
        end
    endfunction

    wire [`APDP_BLW-1:0] src_len = src_from_dma ? dma_burst_length
                                                : hburst_len(hburst);
    wire single_mode = (transfer_mode == `APDP_MODE_SINGLE);
    wire bclk_mode   = (transfer_mode == `APDP_MODE_BCLK);
    wire type1       = (sample_type == `APDP_TYPE1);

    // Half-cycle timeline of one access: whole period grows by wait states
    wire [`APDP_TW+1:0] last_h = rd_q ? per_h * ({1'b0, wait_q} + 1'b1) - 1'b1
                                      : per_h - 1'b1;
    wire [`APDP_TW+1:0] even_last = {last_h[`APDP_TW+1:1], 1'b1};
    wire pulse_on  = (half_q >= fall_h) && (half_q < rise_h + (rd_q ?
                     per_h * {1'b0, wait_q} : {(`APDP_TW+2){1'b0}}));
    wire acc_end   = (half_q >= even_last);
    wire gap_end   = (gap_q == `APDP_GAP_BASE + {1'b0, pause_setting});
    wire burst_end = (left_q <= `APDP_ONE_BL) || single_mode;
    wire more_same = acc_valid && (acc_display == disp_q) && !single_mode;

    assign acc_ready = (state_q == S_IDLE) || (state_q == S_NEXT && more_same && !burst_end);
    assign busy      = (state_q != S_IDLE);

    // ----------------------------------------------------------------
    // Sequencer, two half-cycle steps per clock edge
    // ----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= S_IDLE;
            half_q      <= {(`APDP_TW+2){1'b0}};
            wait_q      <= {`APDP_WAIT_W{1'b0}};
            left_q      <= `APDP_ZERO_BL;
            gap_q       <= 5'h00;
            disp_q      <= {`APDP_DSW{1'b0}};
            rd_q        <= 1'b0;
            addr_q      <= 1'b0;
            be_q        <= 2'h0;
            sel_act_q   <= 1'b0;
            str_act_q   <= 1'b0;
            sampled_q   <= 1'b0;
            rd_data_q   <= `APDP_ZERO_D;
            rd_valid_q  <= 1'b0;
            data_out_q  <= `APDP_ZERO_D;
            data_oe_n_q <= 1'b1;
        end else begin
            rd_valid_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    sel_act_q <= 1'b0;
                    str_act_q <= 1'b0;
                    if (acc_valid) begin
                        disp_q      <= acc_display;
                        left_q      <= (src_len == `APDP_ZERO_BL) ? `APDP_ONE_BL : src_len;
                        rd_q        <= acc_read;
                        addr_q      <= acc_addr;
                        be_q        <= acc_byte_en;
                        wait_q      <= (read_wait_states >= `APDP_WAIT_MAX) ?
                                       `APDP_WAIT_MAX - 1'b1 : read_wait_states;
                        data_out_q  <= acc_wdata;
                        data_oe_n_q <= acc_read;
                        half_q      <= {(`APDP_TW+2){1'b0}};
                        sampled_q   <= 1'b0;
                        state_q     <= S_XFER;
                    end
                end
                S_XFER: begin
                    half_q <= half_q + 2'h2;
                    sel_act_q <= 1'b1;
                    str_act_q <= pulse_on;
                    if (rd_q && !sampled_q && (half_q >= samp_h)) begin
                        rd_data_q  <= din_sync;
                        rd_valid_q <= 1'b1;
                        sampled_q  <= 1'b1;
                    end
                    if (acc_end) begin
                        state_q <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    half_q    <= {(`APDP_TW+2){1'b0}};
                    sampled_q <= 1'b0;
                    str_act_q <= 1'b0;
                    if (more_same && !burst_end) begin
                        // Direction may reverse inside a burst; lines follow the data
                        left_q      <= left_q - 1'b1;
                        rd_q        <= acc_read;
                        addr_q      <= acc_addr;
                        be_q        <= acc_byte_en;
                        data_out_q  <= acc_wdata;
                        data_oe_n_q <= acc_read;
                        sel_act_q   <= !type1 || bclk_mode;
                        state_q     <= S_XFER;
                    end else begin
                        sel_act_q <= 1'b0;
                        state_q   <= single_mode ? S_OFF : S_GAP;
                    end
                end
                S_OFF: begin
                    // Controls stay off for one interface period
                    half_q <= half_q + 2'h2;
                    if (half_q >= per_h - 2'h2) begin
                        gap_q   <= 5'h00;
                        state_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    data_oe_n_q <= 1'b1;
                    gap_q       <= gap_q + 1'b1;
                    if (gap_end) begin
                        gap_q   <= 5'h00;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drive with per-signal polarity; bit set means active high
    // ----------------------------------------------------------------
    wire wr_act = str_act_q && !rd_q && !bclk_mode;
    wire rd_act = str_act_q &&  rd_q && !bclk_mode;
    // 68k: one enable strobe on write_strobe, direction on read_strobe
    wire fam68  = (bus_family == `APDP_FAM_68K);
    wire cs_act = sel_act_q && (type1 && !bclk_mode ? str_act_q || !sel_act_q : 1'b1);
    wire bc_act = bclk_mode && str_act_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            display_select     <= {`APDP_NDISP{1'b1}};
            write_strobe       <= 1'b1;
            read_strobe        <= 1'b1;
            burst_strobe_clock <= 1'b1;
            addr_sel           <= 1'b1;
            byte_enable        <= 2'h3;
        end else begin
            display_select <= {`APDP_NDISP{~signal_polarity_select[0]}};
            if (cs_act && (disp_q < `APDP_NDISP))
                display_select[disp_q] <= signal_polarity_select[0];
            write_strobe <= (fam68 ? (wr_act || rd_act) : wr_act) ^
                            ~signal_polarity_select[1];
            read_strobe  <= (fam68 ? (sel_act_q && rd_q) : rd_act) ^
                            ~signal_polarity_select[2];
            burst_strobe_clock <= bc_act ^ ~signal_polarity_select[3];
            addr_sel     <= (sel_act_q && addr_q) ^ ~signal_polarity_select[4];
            byte_enable  <= (byte_enable_on && sel_act_q ? be_q : 2'h0) ^
                            {2{~signal_polarity_select[5]}};
        end
    end
endmodule

// [test/apdp_props.sv]
/*
 * Checker for the parallel display port: pins at rest, handshake, gaps,
 * write data drive and read result pulses.
 * Assumes it is bound to apdp_port, one clock domain, reset low active.
 */
`timescale 1ns/10ps
`include "apdp_regs.vh"
module apdp_props (
    // Clock and reset
    input wire                   clk,
    input wire                   reset_n,
    // Configuration
    input wire                   bus_family,
    input wire                   sample_type,
    input wire [1:0]             transfer_mode,
    input wire [5:0]             signal_polarity_select,
    // Stream
    input wire                   acc_valid,
    input wire                   acc_ready,
    input wire                   acc_read,
    input wire [`APDP_DW-1:0]    acc_wdata,
    input wire                   busy,
    input wire                   rd_valid_q,
    // Pins
    input wire [`APDP_NDISP-1:0] display_select,
    input wire                   write_strobe,
    input wire                   read_strobe,
    input wire                   burst_strobe_clock,
    input wire [`APDP_DW-1:0]    data_out_q,
    input wire                   data_oe_n_q
);
    wire               sel_on = display_select != {`APDP_NDISP{~signal_polarity_select[0]}};
    wire               take   = acc_valid && acc_ready && !busy;
    reg [`APDP_DW-1:0] wd_q;

    always @(posedge clk) begin
        if (take)
            wd_q <= acc_wdata;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    idle_select_a: assert property (!busy && !$past(busy) && $past(reset_n) |-> !sel_on)
        else $error("select active while idle");
    idle_strobe_a: assert property (!busy && !$past(busy) && $past(reset_n) && !bus_family |->
        write_strobe != signal_polarity_select[1] && read_strobe != signal_polarity_select[2]
        && burst_strobe_clock != signal_polarity_select[3])
        else $error("strobe active while idle");
    take_busy_a: assert property (take |=> busy)
        else $error("accepted word did not start");
    gap_quiet_a: assert property ((transfer_mode != `APDP_MODE_BURST || sample_type)
        && $fell(sel_on) |=> !sel_on [*4])
        else $error("pause after burst too short");
    wdata_out_a: assert property (take && !acc_read |=> ##[0:1] (!data_oe_n_q && data_out_q == wd_q))
        else $error("write data not driven");
    read_release_a: assert property (take && acc_read |=> ##2 data_oe_n_q)
        else $error("bus driven during read");
    rd_pulse_a: assert property (rd_valid_q |=> !rd_valid_q)
        else $error("read result longer than one cycle");
    rd_inside_a: assert property (rd_valid_q |-> $past(busy))
        else $error("read result outside an access");
endmodule

// [test/apdp_display_model.sv]
/*
 * Behavioural smart display on the parallel bus: latches written words at
 * the closing edge of the word strobe and answers reads with a counter.
 * Assumes it sees the port's pins and the same polarity setting.
 */
`timescale 1ns/10ps
module apdp_display_model (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Setup
    input  wire        bus_family,
    input  wire [1:0]  transfer_mode,
    input  wire [5:0]  signal_polarity_select,
    // Port pins
    input  wire [2:0]  display_select,
    input  wire        write_strobe,
    input  wire        read_strobe,
    input  wire        burst_strobe_clock,
    input  wire [15:0] data_out_q,
    input  wire        data_oe_n_q,
    output reg  [15:0] data_in,
    // Latched words
    output reg         wr_seen,
    output reg  [15:0] wr_word
);
    wire [5:0] p = signal_polarity_select;
    wire       sel = display_select != {3{~p[0]}};
    wire       en = transfer_mode == 2'h1 ? burst_strobe_clock == p[3] :
                    (write_strobe == p[1]) || (!bus_family && read_strobe == p[2]);
    reg        en_q;
    // Pins hold their reset level for one edge after release; ignore it
    reg        armed_q;
    reg [15:0] d_q;
    reg [15:0] rd_n;

    initial data_in = 16'h0000;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q    <= 1'b0;
            armed_q <= 1'b0;
            d_q     <= 16'h0000;
            rd_n    <= 16'h5a00;
            wr_seen <= 1'b0;
            wr_word <= 16'h0000;
        end else begin
            armed_q <= 1'b1;
            en_q    <= en && armed_q;
            d_q     <= data_out_q;
            wr_seen <= en_q && !en && !data_oe_n_q;
            wr_word <= d_q;
            if (en_q && !en && data_oe_n_q)
                rd_n <= rd_n + 16'h0001;
        end
    end
    // Released bus toggles so a stale value is never mistaken for data
    always @(posedge clk) begin
        data_in <= (sel && data_oe_n_q && en) ? rd_n : ~data_in;
    end
endmodule

// [test/async_parallel_display_port_bench.sv]
/*
 * Testbench: every family, type and mode, write and read bursts, random
 * pauses, wait states and polarity; words compared with a queue model.
 * Assumes apdp_port, apdp_props and apdp_display_model are compiled first.
 */
`timescale 1ns/10ps
`include "apdp_regs.vh"
module async_parallel_display_port_bench;
    reg         clk = 1'b0, reset_n = 1'b0, bus_family = 1'b0, sample_type = 1'b0;
    reg         byte_enable_on = 1'b0, src_from_dma = 1'b1, acc_valid = 1'b0;
    reg         acc_read = 1'b0, acc_addr = 1'b0;
    reg  [1:0]  transfer_mode = 2'h0, acc_display = 2'h0, acc_byte_en = 2'h0;
    reg  [3:0]  pause_setting = 4'h0;
    reg  [2:0]  read_wait_states = 3'h0, hburst = 3'h3;
    reg  [5:0]  signal_polarity_select = 6'h00;
    reg  [7:0]  fast_clock_period_setting = 8'h02, dma_burst_length = 8'h04;
    reg  [7:0]  write_cycle_length = 8'h19, read_cycle_length = 8'h1b;
    reg  [7:0]  write_strobe_fall_point = 8'h01, write_strobe_rise_point = 8'h15;
    reg  [7:0]  read_strobe_fall_point = 8'h01, read_strobe_rise_point = 8'h17;
    reg  [7:0]  read_sample_point = 8'h13;
    reg  [15:0] acc_wdata = 16'h0000;
    wire        acc_ready, rd_valid_q, busy, write_strobe, read_strobe, burst_strobe_clock;
    wire        addr_sel, data_oe_n_q, wr_seen;
    wire [15:0] rd_data_q, data_out_q, data_in, wr_word;
    wire [2:0]  display_select;
    wire [1:0]  byte_enable;
    integer     err_total = 0, n_compared = 0, nrd, m, i, n, pass;
    reg  [15:0] wq[$];
    reg  [15:0] rq[$];

    apdp_port apdp_port_i (.*);
    apdp_display_model apdp_display_model_i (.*);

    always #10 clk = ~clk;

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task final_report;
        begin
            if (err_total == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Holds the word up until it is taken; valid stays high between words
    task xfer(input rd);
        reg [15:0] v;
        begin
            v = 16'($urandom);
            acc_valid <= 1'b1;
            acc_read  <= rd;
            acc_wdata <= v;
            if (rd) begin
                rq.push_back(16'h5a00 + nrd[15:0]);
                nrd = nrd + 1;
            end else
                wq.push_back(v);
            n = 0;
            @(negedge clk);
            while (acc_ready !== 1'b1 && n < 2000) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 2000)
                err_total = err_total + 1;
            @(posedge clk);
        end
    endtask

    always @(negedge clk) begin
        if (wr_seen === 1'b1)
            chk(wr_word, wq.pop_front());
        if (rd_valid_q === 1'b1)
            chk(rd_data_q, rq.pop_front());
    end

    initial begin
        #1000000;
        err_total = err_total + 1;
        final_report;
    end

    initial begin
        i = $urandom(32'h279584ea);
        for (pass = 0; pass < 2; pass = pass + 1) begin
            reset_n <= 1'b0;
            if (pass == 1) begin
                signal_polarity_select <= 6'($urandom);
                src_from_dma <= 1'b0;
            end
            repeat (8) @(posedge clk);
            reset_n <= 1'b1;
            nrd = 0;
            @(posedge clk);
            for (m = 0; m < 12; m = m + 1) begin
                bus_family <= m[0];
                sample_type <= m[1];
                transfer_mode <= 2'(m / 4);
                pause_setting <= 4'($urandom);
                read_wait_states <= 3'($urandom % 4);
                acc_display <= 2'($urandom % 3);
                acc_addr <= 1'($urandom);
                acc_byte_en <= 2'($urandom);
                byte_enable_on <= 1'($urandom);
                @(posedge clk);
                for (i = 0; i < 8; i = i + 1)
                    xfer(i >= 4);
                acc_valid <= 1'b0;
                n = 0;
                @(posedge clk);
                while (busy !== 1'b0 && n < 2000) begin
                    @(posedge clk);
                    n = n + 1;
                end
                if (n >= 2000)
                    err_total = err_total + 1;
                repeat (24) @(posedge clk);
                chk(16'(wq.size() + rq.size()), 16'h0000);
            end
        end
        final_report;
    end
endmodule

bind apdp_port apdp_props apdp_props_i (.*);
